/* logic/chac_ctrl.sv */
// Command and host access control registers with their side effects.
// Assumes a synchronous register port on i_clk and a command sequencer
// that pulses i_cmd_done when the running command finishes.
`timescale 1ns/10ps
`include "chac_defines.svh"

// Operation
// - Writing one to command bit 7 puts the device into power-down.
// - Command bit 6 set powers down receiver and transmitter.
// - Command bits 4 to 0 are the code given to the sequencer.
// - With the unlock bit set the next write may change host control.
// - The first write after the unlock bit is set clears it.
// - Host-ownership bit set grants the bus to the host controller.
// - Secure-module-ownership bit set grants the bus to the module.
// - Both ownership bits are never one at the same time.
// - Ownership bits are only set after an earlier unlock.
// - Link field 0 off, 1 SPI, 2 light two-wire, 3 two-wire bus.
// - The command register updates itself when the command finishes.
module chac_ctrl
    import chac_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    input  wire logic [6:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    input  wire logic       i_cmd_done,
    input  wire logic       i_cmd_standby,
    output logic      [7:0] o_reg_rdata,
    output logic            o_power_down,
    output logic            o_radio_power_down,
    output logic      [4:0] o_cmd_code,
    output logic            o_cmd_start,
    output logic            o_bus_owner_controller,
    output logic            o_bus_owner_secure_module,
    output logic      [3:0] o_secure_module_link_select
);

    logic       standby_q;
    logic       radio_q;
    logic [4:0] code_q;
    logic       unlock_q;
    logic       own_ctrl_q;
    logic       own_sam_q;
    logic [1:0] link_q;
    logic       wr_cmd;
    logic       wr_host;
    logic       rd_cmd;
    logic       rd_host;
    // Write to the command register, delayed to meet the code at the pins
    logic       cmd_wr_q;
    logic [7:0] cmd_image;
    logic [7:0] host_image;

    function automatic chac_link_e chac_link_decode(input logic [1:0] f);
        case (f)
            2'h0:    chac_link_decode = CHAC_LINK_OFF;
            2'h1:    chac_link_decode = CHAC_LINK_SPI;
            2'h2:    chac_link_decode = CHAC_LINK_LIGHT;
            2'h3:    chac_link_decode = CHAC_LINK_2WIRE;
            default: chac_link_decode = CHAC_LINK_OFF;
        endcase
    endfunction

    // One address compare shared by the write and read decodes
    function automatic logic chac_addr_hit(input logic [6:0] addr,
                                           input logic [6:0] target);
        chac_addr_hit = (addr == target);
    endfunction

    assign wr_cmd  = i_reg_wr && chac_addr_hit(i_reg_addr, `CHAC_ADDR_CMD);
    assign wr_host = i_reg_wr && chac_addr_hit(i_reg_addr, `CHAC_ADDR_HOST);
    assign rd_cmd  = i_reg_rd && chac_addr_hit(i_reg_addr, `CHAC_ADDR_CMD);
    assign rd_host = i_reg_rd && chac_addr_hit(i_reg_addr, `CHAC_ADDR_HOST);

    // Read images: reserved bits are not stored and always read zero
    assign cmd_image  = {standby_q, radio_q, `CHAC_RSV_BIT, code_q};
    assign host_image = {unlock_q, own_ctrl_q, own_sam_q, `CHAC_RSV_BIT,
                         link_q, `CHAC_RSV_PAIR};

    // Command register: software writes, sequencer returns it to idle
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            standby_q <= `CHAC_BIT_CLEAR;
            radio_q   <= `CHAC_BIT_CLEAR;
            code_q    <= `CHAC_CODE_IDLE;
        end
        else if (wr_cmd)
        begin
            // Reserved bit 5 is not stored and reads zero
            standby_q <= i_reg_wdata[`CHAC_CMD_STANDBY_BIT];
            radio_q   <= i_reg_wdata[`CHAC_CMD_RADIO_BIT];
            code_q    <= i_reg_wdata[`CHAC_CMD_CODE_MSB:
                                     `CHAC_CMD_CODE_LSB];
        end
        else
        begin
            // Software write wins over a finish in the same cycle
            if (i_cmd_done)
                code_q <= `CHAC_CODE_IDLE;
            if (!i_cmd_standby && standby_q)
                // Power logic lowering i_cmd_standby means a wake-up
                standby_q <= `CHAC_BIT_CLEAR;
        end
    end

    // Unlock is one-shot: any write to this register consumes it
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            unlock_q <= `CHAC_BIT_CLEAR;
        // Reads leave a pending unlock untouched
        else if (wr_host)
            unlock_q <= unlock_q ? `CHAC_BIT_CLEAR
                                 : i_reg_wdata[`CHAC_HC_UNLOCK_BIT];
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            own_ctrl_q <= `CHAC_BIT_CLEAR;
            own_sam_q  <= `CHAC_BIT_CLEAR;
            link_q     <= `CHAC_LINK_RESET;
        end
        else if (wr_host)
        begin
            // Link type follows every write; only the owners need unlock
            link_q <= i_reg_wdata[`CHAC_HC_LINK_MSB:`CHAC_HC_LINK_LSB];
            // Owners change only when unlocked and not both requested
            if (unlock_q &&
                !(i_reg_wdata[`CHAC_HC_OWN_CTRL_BIT] &&
                  i_reg_wdata[`CHAC_HC_OWN_SAM_BIT]))
            begin
                own_ctrl_q <= i_reg_wdata[`CHAC_HC_OWN_CTRL_BIT];
                own_sam_q  <= i_reg_wdata[`CHAC_HC_OWN_SAM_BIT];
            end
        end
    end

    // Start is held back one edge so the sequencer never sees a stale code
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            cmd_wr_q <= `CHAC_BIT_CLEAR;
        else
            cmd_wr_q <= wr_cmd;
    end

    // Power controls
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_power_down       <= `CHAC_BIT_CLEAR;
            o_radio_power_down <= `CHAC_BIT_CLEAR;
        end
        else
        begin
            o_power_down       <= standby_q;
            o_radio_power_down <= radio_q;
        end
    end

    // Sequencer interface: the code stands, the start pulses once per write
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_cmd_code  <= `CHAC_CODE_IDLE;
            o_cmd_start <= `CHAC_BIT_CLEAR;
        end
        else
        begin
            o_cmd_code  <= code_q;
            o_cmd_start <= cmd_wr_q;
        end
    end

    // Bus ownership grants
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_bus_owner_controller    <= `CHAC_BIT_CLEAR;
            o_bus_owner_secure_module <= `CHAC_BIT_CLEAR;
        end
        else
        begin
            o_bus_owner_controller    <= own_ctrl_q;
            o_bus_owner_secure_module <= own_sam_q;
        end
    end

    // Link type towards the secure module, one-hot
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            o_secure_module_link_select <= CHAC_LINK_OFF;
        else
            o_secure_module_link_select <=
                chac_link_decode(link_q);
    end

    // Read data is registered; valid the cycle after i_reg_rd
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            o_reg_rdata <= `CHAC_RDATA_IDLE;
        else if (rd_cmd)
            o_reg_rdata <= cmd_image;
        else if (rd_host)
            o_reg_rdata <= host_image;
        // Unmapped addresses and idle cycles read as zero
        else
            o_reg_rdata <= `CHAC_RDATA_IDLE;
    end

endmodule // chac_ctrl

/* logic/chac_defines.svh */
// Constants for the command and host access control register pair.
// Assumes an 8-bit register port with 7-bit byte addresses.
`ifndef CHAC_DEFINES_SVH
`define CHAC_DEFINES_SVH

`define CHAC_ADDR_CMD         7'h00
`define CHAC_ADDR_HOST        7'h01
`define CHAC_CMD_STANDBY_BIT  7
`define CHAC_CMD_RADIO_BIT    6
`define CHAC_CMD_CODE_MSB     4
`define CHAC_HC_UNLOCK_BIT    7
`define CHAC_HC_OWN_CTRL_BIT  6
`define CHAC_HC_OWN_SAM_BIT   5
`define CHAC_HC_LINK_MSB      3
`define CHAC_HC_LINK_LSB      2
`define CHAC_CMD_RESET        8'h00
`define CHAC_CODE_IDLE        5'h00
`define CHAC_HC_RESET         8'h00
`define CHAC_CMD_CODE_LSB     0
`define CHAC_BIT_CLEAR        1'h0
`define CHAC_LINK_RESET       2'h0
`define CHAC_RSV_BIT          1'h0
`define CHAC_RSV_PAIR         2'h0
`define CHAC_RDATA_IDLE       8'h00

`endif

/* logic/chac_pkg.sv */
// Types shared by the command and host access control block.
// Assumes nothing of its surroundings.
package chac_pkg;
    typedef enum logic [3:0] {
        CHAC_LINK_OFF   = 4'b0001,
        CHAC_LINK_SPI   = 4'b0010,
        CHAC_LINK_LIGHT = 4'b0100,
        CHAC_LINK_2WIRE = 4'b1000
    } chac_link_e;
endpackage

/* tb/chac_checker.sv */
// Port checker for the command and host access control block.
// Assumes chac_ctrl port names; bound to every instance below.
`timescale 1ns/10ps
module chac_checker
(
    input wire logic       i_clk, i_sys_rst, i_reg_wr, i_reg_rd, i_cmd_done,
    input wire logic [6:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata, o_reg_rdata,
    input wire logic [4:0] o_cmd_code,
    input wire logic [3:0] o_secure_module_link_select,
    input wire logic       o_power_down, o_radio_power_down, o_cmd_start,
    input wire logic       o_bus_owner_controller, o_bus_owner_secure_module
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    wire cw = i_reg_wr && i_reg_addr == 7'h00;
    wire hw = i_reg_wr && i_reg_addr == 7'h01;
    logic unl_q;
    // Bus-side view of the one-shot unlock, rebuilt from the writes seen
    always_ff @(posedge i_clk or posedge i_sys_rst)
        if (i_sys_rst) unl_q <= 1'b0;
        else if (hw) unl_q <= !unl_q && i_reg_wdata[7];
    AST_CODE: assert property (cw ##1 !(cw || i_cmd_done) |=>
        o_cmd_code == $past(i_reg_wdata[4:0], 2)) else $error("code");
    AST_OFF: assert property (cw && i_reg_wdata[7] ##1 !cw |=>
        o_power_down) else $error("standby");
    AST_RADIO: assert property (cw ##1 !cw |=>
        o_radio_power_down == $past(i_reg_wdata[6], 2)) else $error("radio");
    AST_DONE: assert property (i_cmd_done && !cw ##1 !cw |=>
        o_cmd_code == 5'h00) else $error("done");
    AST_START: assert property (cw |-> ##2 o_cmd_start)
        else $error("start");
    AST_EXCL: assert property (!(o_bus_owner_controller &&
        o_bus_owner_secure_module)) else $error("owners");
    AST_LOCK: assert property ($rose(o_bus_owner_controller ||
        o_bus_owner_secure_module) |-> $past(hw && unl_q, 2))
        else $error("lock");
    AST_LINK: assert property (hw ##1 !hw |=>
        o_secure_module_link_select == 4'h1 << $past(i_reg_wdata[3:2], 2))
        else $error("link");
    AST_RSV: assert property (i_reg_rd && i_reg_addr == 7'h01 |=>
        o_reg_rdata[4] == 1'b0 && o_reg_rdata[1:0] == 2'h0) else $error("rsv");
    cover property (cw ##2 o_cmd_start);
    cover property ($rose(o_bus_owner_secure_module));
    cover property (i_cmd_done);
endmodule // chac_checker

bind chac_ctrl chac_checker chac_checker_i (.*);

/* tb/chac_seq_model.sv */
// Command sequencer model: finishes each started command after a delay.
// Assumes start pulse and code from chac_ctrl; wakes it as a command ends.
`timescale 1ns/10ps
module chac_seq_model
(
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_start,
    input  wire logic [4:0] i_code,
    output logic            o_done,
    output logic            o_standby
);
    logic [3:0] cnt_q;
    // Idle code has nothing to run, so it never reports completion
    always_ff @(posedge i_clk or posedge i_sys_rst)
        if (i_sys_rst) cnt_q <= 4'h0;
        else if (i_start && i_code != 5'h00) cnt_q <= 4'h6;
        else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
    assign o_done = cnt_q == 4'h1;
    // Wake-up coincides with completion
    assign o_standby = cnt_q != 4'h1;
endmodule // chac_seq_model

/* tb/testbench.sv */
// Self-checking bench for chac_ctrl with a sequencer model.
// Assumes a 50 MHz clock and an active-high asynchronous reset.
`timescale 1ns/10ps
module testbench;
    logic i_clk = 0, i_sys_rst = 1, i_reg_wr = 0, i_reg_rd = 0;
    logic i_cmd_done, i_cmd_standby, o_cmd_start, o_power_down;
    logic o_radio_power_down, o_bus_owner_controller, o_bus_owner_secure_module;
    logic [6:0] i_reg_addr = 7'h00;
    logic [7:0] i_reg_wdata = 8'h00, o_reg_rdata;
    logic [4:0] o_cmd_code;
    logic [3:0] o_secure_module_link_select;
    int bad_count = 0, check_count = 0;
    wire [1:0] owners = {o_bus_owner_secure_module, o_bus_owner_controller};
    chac_ctrl chac_ctrl_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_cmd_done(i_cmd_done),
        .i_cmd_standby(i_cmd_standby), .o_reg_rdata(o_reg_rdata),
        .o_power_down(o_power_down), .o_radio_power_down(o_radio_power_down),
        .o_cmd_code(o_cmd_code), .o_cmd_start(o_cmd_start),
        .o_bus_owner_controller(o_bus_owner_controller),
        .o_bus_owner_secure_module(o_bus_owner_secure_module),
        .o_secure_module_link_select(o_secure_module_link_select));
    chac_seq_model chac_seq_model_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_start(o_cmd_start), .i_code(o_cmd_code), .o_done(i_cmd_done),
        .o_standby(i_cmd_standby));
    initial forever #10 i_clk = ~i_clk;
    task automatic chk(string n, logic [7:0] s, logic [7:0] e);
        check_count++;
        if (s !== e)
        begin
            bad_count++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic finish_test;
        if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Returns one edge after the write, when the outputs have settled
    task automatic wr8(logic [6:0] a, logic [7:0] d);
        @(posedge i_clk) #1 {i_reg_wr, i_reg_addr, i_reg_wdata} = {1'b1, a, d};
        @(posedge i_clk) #1 i_reg_wr = 0;
        @(posedge i_clk) #1;
    endtask
    task automatic rd8(logic [6:0] a, logic [7:0] e);
        @(posedge i_clk) #1 {i_reg_rd, i_reg_addr} = {1'b1, a};
        @(posedge i_clk) #1 i_reg_rd = 0;
        chk("rdata", o_reg_rdata, e);
    endtask
    task automatic t_cmd;
        int n = 0;
        wr8(7'h00, 8'hc5);
        chk("start", o_cmd_start, 1);
        chk("code", o_cmd_code, 8'h05);
        chk("standby", o_power_down, 1);
        chk("radio", o_radio_power_down, 1);
        while (o_cmd_code !== 5'h00 && n < 20)
        begin
            @(posedge i_clk) #1;
            n++;
        end
        chk("done", o_cmd_code, 0);
        if (n == 20) finish_test();
        chk("wake", o_power_down, 0);
        rd8(7'h00, 8'h40);
    endtask
    task automatic t_own;
        wr8(7'h01, 8'h40);
        chk("locked", o_bus_owner_controller, 0);
        wr8(7'h01, 8'h80);
        wr8(7'h01, 8'h40);
        chk("host", o_bus_owner_controller, 1);
        rd8(7'h01, 8'h40);
        wr8(7'h01, 8'h80);
        rd8(7'h01, 8'hc0);
        wr8(7'h01, 8'h60);
        chk("both", owners, 1);
        wr8(7'h01, 8'h80);
        wr8(7'h01, 8'h20);
        chk("sam", owners, 2);
        for (int k = 0; k < 4; k++)
        begin
            wr8(7'h01, {4'h0, k[1:0], 2'b00});
            chk("link", o_secure_module_link_select, 4'h1 << k);
        end
        rd8(7'h02, 8'h00);
    endtask
    // Mid-run reset must drop the grants and return the link select to off
    task automatic t_rst;
        @(posedge i_clk) #1 i_sys_rst = 1;
        @(posedge i_clk) #1 i_sys_rst = 0;
        chk("rst_link", o_secure_module_link_select, 4'h1);
        wr8(7'h01, 8'h40);
        chk("rst_own", owners, 0);
    endtask
    initial
    begin
        repeat (2) @(posedge i_clk);
        #1 i_sys_rst = 0;
        t_cmd();
        t_own();
        t_rst();
        finish_test();
    end
endmodule // testbench
